// ---- comm_fault_mask_bank.sv ----
// Fault mask bank: four 8-bit mask registers over AHB-Lite, gating fault flags.
// Assumes a single core clock, synchronous reset and a single AHB-Lite master.
// Contract
// [RL1] A mask bit of one blocks its fault flag, zero lets it through.
// [RL2] Tone mask bit 0 is heartbeat overspeed, bit 1 heartbeat loss, bit 2 recovery, 7..3 spare.
// [RL3] Host mask bit 0 is stop bit error, bit 1 link reset, bit 2 link clear, 7..3 spare.
// [RL4] Relayed mask bit 3 is frame start, bit 2 byte error, bit 0 checksum, others spare.
// [RL5] Relayed mask bit 0 suppresses checksum failures on relayed frames.
// [RL6] All masks reset to zero and spare bits store but gate nothing.
`timescale 1ns/1ps
module comm_fault_mask_bank (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  tone_fault_flags,
  input  wire logic [7:0]  host_uart_fault_flags,
  input  wire logic [7:0]  received_frame_fault_flags,
  input  wire logic [7:0]  relayed_frame_fault_flags,
  output logic      [7:0]  tone_fault_out,
  output logic      [7:0]  host_uart_fault_out,
  output logic      [7:0]  received_frame_fault_out,
  output logic      [7:0]  relayed_frame_fault_out,
  output logic             irq
);
  mask_bus_if bus ();

  logic [7:0] tone_fault_mask;
  logic [7:0] host_uart_fault_mask;
  logic [7:0] received_frame_fault_mask;
  logic [7:0] relayed_frame_fault_mask;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [3:0] group_active;
  logic [3:0] group_prev;
  logic       wr_pending;
  logic [5:0] wr_idx_q;
  logic       rd_pending;
  logic [5:0] rd_idx_q;
  logic       addr_ok;
  logic [5:0] cur_idx;

  // Address phase capture; only aligned word transfers are honoured
  always_comb begin
    cur_idx = haddr[7:2];
    addr_ok = hsel && hready && (htrans == fault_mask_pkg::HTRANS_NONSEQ)
              && (hsize == fault_mask_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      wr_idx_q   <= 6'h00;
      rd_idx_q   <= 6'h00;
    end else begin
      wr_pending <= addr_ok && hwrite;
      rd_pending <= addr_ok && !hwrite;
      if (addr_ok) begin
        wr_idx_q <= cur_idx;
        rd_idx_q <= cur_idx;
      end
    end
  end

  assign bus.wr_en   = wr_pending;
  assign bus.wr_idx  = wr_idx_q;
  assign bus.wr_data = hwdata[7:0];

  // Zero-wait slave: always ready, always OKAY
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data registered at the address phase so it stands during the data phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      if (cur_idx == fault_mask_pkg::IDX_TONE) begin
        hrdata <= {24'h000000, tone_fault_mask};
      end else if (cur_idx == fault_mask_pkg::IDX_HOST) begin
        hrdata <= {24'h000000, host_uart_fault_mask};
      end else if (cur_idx == fault_mask_pkg::IDX_RECV) begin
        hrdata <= {24'h000000, received_frame_fault_mask};
      end else if (cur_idx == fault_mask_pkg::IDX_RELAY) begin
        hrdata <= {24'h000000, relayed_frame_fault_mask};
      end else if (cur_idx == fault_mask_pkg::IDX_IRQ_STAT) begin
        hrdata <= {28'h0000000, irq_status};
      end else if (cur_idx == fault_mask_pkg::IDX_IRQ_EN) begin
        hrdata <= {28'h0000000, irq_enable};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  mask_gate #(
    .INDEX (fault_mask_pkg::IDX_TONE),
    .LIVE  (fault_mask_pkg::TONE_LIVE)
  ) u_tone (
    .core_clk  (core_clk),
    .rst       (rst),
    .bus       (bus),
    .flags     (tone_fault_flags),
    .mask      (tone_fault_mask),
    .signalled (tone_fault_out)
  ); // RL2

  mask_gate #(
    .INDEX (fault_mask_pkg::IDX_HOST),
    .LIVE  (fault_mask_pkg::HOST_LIVE)
  ) u_host (
    .core_clk  (core_clk),
    .rst       (rst),
    .bus       (bus),
    .flags     (host_uart_fault_flags),
    .mask      (host_uart_fault_mask),
    .signalled (host_uart_fault_out)
  ); // RL3

  mask_gate #(
    .INDEX (fault_mask_pkg::IDX_RECV),
    .LIVE  (fault_mask_pkg::RECV_LIVE)
  ) u_recv (
    .core_clk  (core_clk),
    .rst       (rst),
    .bus       (bus),
    .flags     (received_frame_fault_flags),
    .mask      (received_frame_fault_mask),
    .signalled (received_frame_fault_out)
  );

  mask_gate #(
    .INDEX (fault_mask_pkg::IDX_RELAY),
    .LIVE  (fault_mask_pkg::RELAY_LIVE)
  ) u_relay (
    .core_clk  (core_clk),
    .rst       (rst),
    .bus       (bus),
    .flags     (relayed_frame_fault_flags),
    .mask      (relayed_frame_fault_mask),
    .signalled (relayed_frame_fault_out)
  ); // RL4 RL5

  // Event per group: rising edge of the OR of its unmasked live fault flags
  always_comb begin
    group_active[0] = |(tone_fault_flags & ~tone_fault_mask & fault_mask_pkg::TONE_LIVE);
    group_active[1] = |(host_uart_fault_flags & ~host_uart_fault_mask
                        & fault_mask_pkg::HOST_LIVE);
    group_active[2] = |(received_frame_fault_flags & ~received_frame_fault_mask
                        & fault_mask_pkg::RECV_LIVE);
    group_active[3] = |(relayed_frame_fault_flags & ~relayed_frame_fault_mask
                        & fault_mask_pkg::RELAY_LIVE); // RL1 RL5
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      group_prev <= 4'h0;
    end else begin
      group_prev <= group_active;
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status <= 4'h0;
    end else if (wr_pending && wr_idx_q == fault_mask_pkg::IDX_IRQ_CLR) begin
      irq_status <= (irq_status & ~hwdata[3:0]) | (group_active & ~group_prev);
    end else begin
      irq_status <= irq_status | (group_active & ~group_prev);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_enable <= 4'h0;
    end else if (wr_pending && wr_idx_q == fault_mask_pkg::IDX_IRQ_EN) begin
      irq_enable <= hwdata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end
endmodule

// ---- fault_mask_pkg.sv ----
// Constants shared by the fault mask bank: register map, field layouts, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package fault_mask_pkg;
  localparam int          MASK_W       = 8;
  localparam int          ADDR_W       = 8;
  // Printed offsets are not all multiples of four, so they are register indices
  localparam logic [5:0]  IDX_TONE     = 6'h07;
  localparam logic [5:0]  IDX_HOST     = 6'h08;
  localparam logic [5:0]  IDX_RECV     = 6'h09;
  localparam logic [5:0]  IDX_RELAY    = 6'h0a;
  localparam logic [5:0]  IDX_IRQ_STAT = 6'h10;
  localparam logic [5:0]  IDX_IRQ_EN   = 6'h11;
  localparam logic [5:0]  IDX_IRQ_CLR  = 6'h12;
  localparam logic [7:0]  MASK_RESET   = 8'h00;
  localparam int          NUM_SRC      = 4;
  // Tone register fields
  localparam int          HEARTBEAT_OVERSPEED_BIT = 0;
  localparam int          HEARTBEAT_LOSS_BIT      = 1;
  localparam int          FAULT_RECOVERY_BIT      = 2;
  // Host register fields
  localparam int          STOP_BIT_ERROR_BIT      = 0;
  localparam int          LINK_RESET_DETECT_BIT   = 1;
  localparam int          LINK_CLEAR_DETECT_BIT   = 2;
  // Frame register fields
  localparam int          CHECKSUM_ERROR_BIT      = 0;
  localparam int          UNEXPECTED_FRAME_BIT    = 1;
  localparam int          BYTE_ERROR_BIT          = 2;
  localparam int          FRAME_START_ERROR_BIT   = 3;
  localparam int          TRANSMIT_DISABLED_BIT   = 4;
  localparam int          INTERNAL_ERROR_BIT      = 5;
  // Functional bits per register; spare bits are excluded
  localparam logic [7:0]  TONE_LIVE    = 8'h07;
  localparam logic [7:0]  HOST_LIVE    = 8'h07;
  localparam logic [7:0]  RECV_LIVE    = 8'h3f;
  localparam logic [7:0]  RELAY_LIVE   = 8'h0d;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage

// ---- mask_bank_properties.sv ----
// Port-level checks for the fault mask bank.
// Bound into comm_fault_mask_bank; one clock, synchronous reset.
`timescale 1ns/1ps
module mask_bank_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  tone_fault_flags,
  input wire logic [7:0]  relayed_frame_fault_flags,
  input wire logic [7:0]  tone_fault_out,
  input wire logic [7:0]  host_uart_fault_out,
  input wire logic [7:0]  received_frame_fault_out,
  input wire logic [7:0]  relayed_frame_fault_out,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_tone_spare_quiet:
    assert property ((tone_fault_out & ~fault_mask_pkg::TONE_LIVE) == 8'h00)
    else $error("tone spare output set");
  chk_host_spare_quiet:
    assert property ((host_uart_fault_out & ~fault_mask_pkg::HOST_LIVE) == 8'h00)
    else $error("host spare output set");
  chk_relay_spare_quiet:
    assert property ((relayed_frame_fault_out & ~fault_mask_pkg::RELAY_LIVE) == 8'h00)
    else $error("relayed spare output set");
  chk_recv_spare_quiet:
    assert property ((received_frame_fault_out & ~fault_mask_pkg::RECV_LIVE) == 8'h00)
    else $error("received spare output set");
  chk_tone_needs_flag:
    assert property ((tone_fault_out & ~$past(tone_fault_flags)) == 8'h00)
    else $error("tone output without its flag");
  chk_relay_checksum_gate:
    assert property (relayed_frame_fault_out[0] |-> $past(relayed_frame_fault_flags[0]))
    else $error("checksum output without its flag");
  chk_reset_outputs_clear:
    assert property ($past(rst) |-> !irq && tone_fault_out == 8'h00
                     && relayed_frame_fault_out == 8'h00)
    else $error("outputs not clear after reset");
  chk_read_idle_zero:
    assert property (!$past(hsel && htrans == fault_mask_pkg::HTRANS_NONSEQ && !hwrite)
                     |-> hrdata == 32'h0)
    else $error("read data outside a read");
  chk_bus_always_okay:
    assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cover property (relayed_frame_fault_out[0]);
  cover property ($rose(irq));
  cover property (hrdata != 32'h0);
endmodule
bind comm_fault_mask_bank mask_bank_properties i_props (.core_clk, .rst, .hsel, .htrans,
  .hwrite, .hrdata, .hreadyout, .hresp, .tone_fault_flags, .relayed_frame_fault_flags,
  .tone_fault_out, .host_uart_fault_out, .received_frame_fault_out,
  .relayed_frame_fault_out, .irq);

// ---- mask_bus_if.sv ----
// Write path between the bus slave and the mask gates.
// Assumes one clock domain.
`timescale 1ns/1ps
interface mask_bus_if;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  modport master (output wr_en, output wr_idx, output wr_data);
  modport slave  (input  wr_en, input  wr_idx, input  wr_data);
endinterface

// ---- mask_gate.sv ----
// One mask register and its gate onto a group of fault flags.
// Assumes writes arrive over mask_bus_if in the core clock domain.
`timescale 1ns/1ps
module mask_gate #(
  parameter logic [5:0] INDEX = 6'h00,
  parameter logic [7:0] LIVE  = 8'h00
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  mask_bus_if.slave        bus,
  input  wire logic [7:0]  flags,
  output logic      [7:0]  mask,
  output logic      [7:0]  signalled
);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask <= fault_mask_pkg::MASK_RESET; // RL6
    end else if (bus.wr_en && bus.wr_idx == INDEX) begin
      mask <= bus.wr_data;
    end
  end

  // Set mask bit suppresses its flag; spare bits never pass a flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      signalled <= fault_mask_pkg::MASK_RESET;
    end else begin
      signalled <= flags & ~mask & LIVE; // RL1 RL6
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the fault mask bank over AHB-Lite.
// Drives all ports itself; hready follows hreadyout.
`timescale 1ns/1ps
module testbench;
  logic        core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [7:0]  haddr, m;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0]  flg [4];
  logic [7:0]  outv [4];
  logic [7:0]  live [4];
  int          fails, comparisons;
  assign hready = hreadyout;
  comm_fault_mask_bank i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq,
    .tone_fault_flags(flg[0]), .host_uart_fault_flags(flg[1]),
    .received_frame_fault_flags(flg[2]), .relayed_frame_fault_flags(flg[3]),
    .tone_fault_out(outv[0]), .host_uart_fault_out(outv[1]),
    .received_frame_fault_out(outv[2]), .relayed_frame_fault_out(outv[3]));
  task automatic report_and_stop;
    $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask
  // Address phase, then data phase; read data taken at the closing edge
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    hwrite <= wr;
    htrans <= fault_mask_pkg::HTRANS_NONSEQ;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    rd = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = fault_mask_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    fails = 0;
    comparisons = 0;
    flg = '{8'h00, 8'h00, 8'h00, 8'h00};
    live = '{fault_mask_pkg::TONE_LIVE, fault_mask_pkg::HOST_LIVE,
             fault_mask_pkg::RECV_LIVE, fault_mask_pkg::RELAY_LIVE};
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int g = 0; g < 4; g++) begin
      xfer(1'b0, fault_mask_pkg::IDX_TONE + 6'(g), 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, fault_mask_pkg::IDX_TONE + 6'(g), 32'h5a5a_5aa0 | g);
      xfer(1'b0, fault_mask_pkg::IDX_TONE + 6'(g), 32'h0);
      chk(rd, 32'h0000_00a0 | g);
    end
    xfer(1'b1, 6'h0c, 32'hff);
    xfer(1'b0, 6'h0c, 32'h0);
    chk(rd, 32'h0);
    $display("Test reset and readback done");
    for (int g = 0; g < 4; g++) begin
      flg[g] <= 8'hff;
      for (int b = 0; b < 9; b++) begin
        m = (b == 8) ? ~live[g] : 8'(1 << b);
        xfer(1'b1, fault_mask_pkg::IDX_TONE + 6'(g), {24'h0, m});
        repeat (2) @(posedge core_clk);
        chk({24'h0, outv[g]}, {24'h0, live[g] & ~m});
      end
      flg[g] <= 8'h00;
      xfer(1'b1, fault_mask_pkg::IDX_TONE + 6'(g), 32'h0);
    end
    $display("Test mask gating done");
    xfer(1'b1, fault_mask_pkg::IDX_IRQ_CLR, 32'hf);
    xfer(1'b1, fault_mask_pkg::IDX_IRQ_EN, 32'hf);
    for (int g = 0; g < 4; g++) begin
      flg[g] <= 8'h01;
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b0, fault_mask_pkg::IDX_IRQ_STAT, 32'h0);
      chk(rd, 32'h1 << g);
      flg[g] <= 8'h00;
      xfer(1'b1, fault_mask_pkg::IDX_IRQ_CLR, 32'h1 << g);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
    end
    xfer(1'b1, fault_mask_pkg::IDX_TONE, 32'h1);
    xfer(1'b1, fault_mask_pkg::IDX_IRQ_EN, 32'h0);
    flg[0] <= 8'h01;
    flg[1] <= 8'h01;
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, fault_mask_pkg::IDX_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    xfer(1'b1, fault_mask_pkg::IDX_IRQ_EN, 32'h2);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    $display("Test interrupts done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    xfer(1'b0, fault_mask_pkg::IDX_TONE, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("Test second reset done");
    report_and_stop();
  end
endmodule
